// ==== ebc_pkg.sv ====
// Constants and types for the external bus channel decode and address output block
//
// Contract
// - Eight channels, each with its own control register affecting only that channel.
// - Global ack/ready mode bit: 0 dynamic (reset), 1 static, all channels.
// - Address-hold bit 1 (reset) holds pins one cycle after strobe rises.
// - Pins 14:13 at reset choose system clock divider: quarter, third, half, equal.
// - Pin 8 at reset enables channel 0 as boot channel.
// - Pins 7:6 at reset set channel 0 speed.
// - Data pin 5 at reset selects byte enables (0) or byte write enables (1).
// - Channel 0 wait bit 0 is inverted data pin 4 at reset.
// - Bus width 01 32-bit, 10 16-bit, 11 8-bit; channel 0 from data pins 1:0.
// - Select when masked address bits 35:20 equal masked base.
// - Size code 0 is 1 MB; each step doubles, up to 1 GB; rest reserved.
// - Upper eight address bits appear on pins 19:12 while the strobe is low.
// - Strobe on first access after reset, then only when upper address changes.
// - Small channels never strobe upper address after the first access.
// - Wide accesses split into cycles starting at the lowest address.
// - 32-bit mode: lower pins carry bits 21:2, upper carries 29:22.
// - 32-bit: up to word one cycle, doubleword two, burst beat two.
// - 16-bit mode: lower pins carry bits 20:1, upper carries 28:21.
// - 16-bit: byte/half one cycle, word two, doubleword four, burst four.
// - 8-bit mode: lower pins carry bits 19:0, upper carries 27:20.
// - 8-bit: byte one, half two, word four, doubleword eight, burst eight.
package ebc_pkg;
    localparam int NUM_CH = 8;
    // Register byte offsets
    localparam logic [6:0] OFS_CH_STRIDE = 7'h08;
    localparam logic [6:0] OFS_CH_BASE = 7'h04;
    localparam logic [6:0] OFS_CFG = 7'h40;
    localparam logic [6:0] OFS_STAT = 7'h44;
    // Channel control word fields
    localparam int F_EN = 0;
    localparam int F_SPD = 1;
    localparam int F_BLM = 3;
    localparam int F_WT = 4;
    localparam int F_BW = 10;
    localparam int F_SZ = 12;
    // Chip config fields
    localparam int F_ARM = 0;
    localparam int F_HOLD = 1;
    localparam int F_DIV = 2;
    // Strap pin positions
    localparam int P_DIV = 13;
    localparam int P_EN0 = 8;
    localparam int P_SPD0 = 6;
    localparam int P_BLM0 = 5;
    localparam int P_WT0 = 4;
    localparam int P_BW0 = 0;
    // Encodings
    localparam logic [1:0] BW_32 = 2'h1;
    localparam logic [1:0] BW_16 = 2'h2;
    localparam logic [1:0] BW_8 = 2'h3;
    localparam logic [3:0] SZ_MAX = 4'hA;
    localparam logic [1:0] SZ_DWORD = 2'h3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] CH_LO_RST = 16'h0000;
    localparam logic [11:0] LOW_ZERO = 12'h000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ADDR = 5'h02,
        ST_UPPER = 5'h04,
        ST_HOLD = 5'h08,
        ST_CYCLE = 5'h10
    } ebc_state_t;
endpackage

// ==== ebc_ext_bus_ctrl.sv ====
// External bus controller: channel decode, boot straps, upper/lower address output
`timescale 1ns/100ps
`default_nettype none
module ebc_ext_bus_ctrl
    import ebc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [6:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [6:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Boot strap pins, sampled while resetn is low
    input wire logic [19:0] strapAddr,
    input wire logic [5:0] strapData,
    // Internal bus access request
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [35:0] reqAddr,
    input wire logic [1:0] reqSize,
    input wire logic reqBurst,
    output logic reqDone,
    output logic reqHit,
    // External address side
    output logic [19:0] extAddr,
    output logic upperAddrStrobeN,
    output logic extCycle,
    output logic [2:0] extChan,
    output logic [1:0] extBusWidth,
    output logic [1:0] extSpeed,
    output logic extByteWriteMode,
    output logic [5:0] extWaitCount,
    output logic ackReadyPinMode,
    output logic systemClockTick
);
    typedef struct packed {
        logic [NUM_CH-1:0][15:0] chLo;
        logic [NUM_CH-1:0][15:0] chBase;
        logic ack_ready_pin_mode;
        logic addrHold;
        logic [1:0] sysDiv;
        logic [1:0] divCnt;
        logic sysTick;
        logic awHave;
        logic [6:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        ebc_state_t state;
        logic firstDone;
        logic [7:0] lastUpper;
        logic [35:0] curAddr;
        logic [3:0] cyclesLeft;
        logic [2:0] curChan;
        logic [1:0] widthLog;
        logic needUpper;
        logic [19:0] extAddr;
        logic strobeN;
        logic extCycle;
        logic reqDone;
        logic reqHit;
    } ebc_regs_t;

    ebc_regs_t r_q;
    ebc_regs_t r_d;

    // ------------------------------------------------------------
    // Channel decode
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] chHit;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_dec
            logic [3:0] sz;
            logic [15:0] mask;
            assign sz = r_q.chLo[gi][F_SZ +: 4];
            // Size code n gives n low mask ones
            assign mask = 16'(~(16'hFFFF << sz));
            assign chHit[gi] = r_q.chLo[gi][F_EN] && (sz <= SZ_MAX)
                && ((reqAddr[35:20] & ~mask) == (r_q.chBase[gi] & ~mask));
        end
    endgenerate

    // Lowest hit wins; overlapping windows are the software's problem
    logic [2:0] hitIdx;
    always_comb begin
        hitIdx = 3'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (chHit[i]) begin
                hitIdx = 3'(i);
            end
        end
    end

    // Width code to log2 of bytes per external cycle
    function automatic logic [1:0] width_log(input logic [1:0] bw);
        case (bw)
            BW_16: width_log = 2'h1;
            BW_8: width_log = 2'h0;
            default: width_log = 2'h2;
        endcase
    endfunction

    // Upper address and lower address for the current width
    function automatic logic [7:0] upper_of(input logic [35:0] a, input logic [1:0] wl);
        case (wl)
            2'h2: upper_of = a[29:22];
            2'h1: upper_of = a[28:21];
            default: upper_of = a[27:20];
        endcase
    endfunction

    function automatic logic [19:0] lower_of(input logic [35:0] a, input logic [1:0] wl);
        case (wl)
            2'h2: lower_of = a[21:2];
            2'h1: lower_of = a[20:1];
            default: lower_of = a[19:0];
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [15:0] selLo;
    logic [1:0] reqWl;
    logic [1:0] spanLog;
    logic [1:0] shiftCnt;
    logic [7:0] curUpper;
    logic [31:0] rdVal;
    logic rdOk;
    logic [2:0] rdCh;
    logic [2:0] wrCh;
    logic [15:0] wrLo;
    logic [15:0] wrHi;

    always_comb begin
        r_d = r_q;
        selLo = r_q.chLo[hitIdx];
        reqWl = width_log(selLo[F_BW +: 2]);
        spanLog = reqBurst ? SZ_DWORD : reqSize;
        shiftCnt = (spanLog > reqWl) ? 2'(spanLog - reqWl) : 2'h0;
        curUpper = upper_of(r_q.curAddr, r_q.widthLog);
        r_d.reqDone = 1'b0;
        r_d.extCycle = 1'b0;

        // System clock output tick divider
        r_d.sysTick = 1'b0;
        if (r_q.divCnt == 2'h0) begin
            r_d.sysTick = 1'b1;
            r_d.divCnt = 2'(~r_q.sysDiv);
        end else begin
            r_d.divCnt = 2'(r_q.divCnt - 2'h1);
        end

        // Register writes; address and data may arrive in either order
        if (awvalid && !r_q.awHave && !r_q.bValid) begin
            r_d.awHave = 1'b1;
            r_d.awAddr = awaddr;
        end
        if (wvalid && !r_q.wHave && !r_q.bValid) begin
            r_d.wHave = 1'b1;
            r_d.wData = wdata;
            r_d.wStrb = wstrb;
        end
        wrCh = r_q.awAddr[5:3];
        wrLo = r_q.chLo[wrCh];
        wrHi = r_q.chBase[wrCh];
        for (int b = 0; b < 2; b++) begin
            if (r_q.wStrb[b]) begin
                wrLo[b*8 +: 8] = r_q.wData[b*8 +: 8];
                wrHi[b*8 +: 8] = r_q.wData[b*8 +: 8];
            end
        end
        if (r_q.awHave && r_q.wHave) begin
            r_d.awHave = 1'b0;
            r_d.wHave = 1'b0;
            r_d.bValid = 1'b1;
            r_d.bResp = RESP_OK;
            if (r_q.awAddr < OFS_CFG) begin
                if ((r_q.awAddr & OFS_CH_BASE) != 7'h00) begin
                    r_d.chBase[wrCh] = wrHi;
                end else begin
                    r_d.chLo[wrCh] = wrLo;
                end
            end else if (r_q.awAddr[6:2] == OFS_CFG[6:2]) begin
                if (r_q.wStrb[0]) begin
                    r_d.ack_ready_pin_mode = r_q.wData[F_ARM];
                    r_d.addrHold = r_q.wData[F_HOLD];
                end
            end else if (r_q.awAddr[6:2] != OFS_STAT[6:2]) begin
                r_d.bResp = RESP_SLVERR;
            end
        end else if (r_q.bValid && bready) begin
            r_d.bValid = 1'b0;
        end

        // Register reads
        rdCh = araddr[5:3];
        rdOk = 1'b1;
        rdVal = 32'h0000_0000;
        if (araddr < OFS_CFG) begin
            if ((araddr & OFS_CH_BASE) != 7'h00) begin
                rdVal[15:0] = r_q.chBase[rdCh];
            end else begin
                rdVal[15:0] = r_q.chLo[rdCh];
            end
        end else if (araddr[6:2] == OFS_CFG[6:2]) begin
            rdVal[F_ARM] = r_q.ack_ready_pin_mode;
            rdVal[F_HOLD] = r_q.addrHold;
            rdVal[F_DIV +: 2] = r_q.sysDiv;
        end else if (araddr[6:2] == OFS_STAT[6:2]) begin
            rdVal[7:0] = r_q.lastUpper;
            rdVal[8] = r_q.firstDone;
            rdVal[11:9] = r_q.curChan;
            rdVal[12] = (r_q.state != ST_IDLE);
        end else begin
            rdOk = 1'b0;
        end
        if (arvalid && !r_q.rValid) begin
            r_d.rValid = 1'b1;
            r_d.rData = rdVal;
            r_d.rResp = rdOk ? RESP_OK : RESP_SLVERR;
        end else if (r_q.rValid && rready) begin
            r_d.rValid = 1'b0;
        end

        // ------------------------------------------------------------
        // External access sequencer
        // ------------------------------------------------------------
        case (r_q.state)
            ST_IDLE: begin
                if (reqValid) begin
                    if (chHit == '0) begin
                        r_d.reqDone = 1'b1;
                        r_d.reqHit = 1'b0;
                    end else begin
                        r_d.curAddr = reqAddr;
                        r_d.curChan = hitIdx;
                        r_d.widthLog = reqWl;
                        r_d.cyclesLeft = 4'(4'h1 << shiftCnt);
                        // Channel too large for the lower pins alone needs the upper latch
                        r_d.needUpper = (selLo[F_SZ +: 4] > {2'h0, reqWl});
                        r_d.state = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (!r_q.firstDone || (r_q.needUpper && curUpper != r_q.lastUpper)) begin
                    r_d.extAddr = {curUpper, LOW_ZERO};
                    r_d.strobeN = 1'b0;
                    r_d.lastUpper = curUpper;
                    r_d.firstDone = 1'b1;
                    r_d.state = ST_UPPER;
                end else begin
                    r_d.extAddr = lower_of(r_q.curAddr, r_q.widthLog);
                    r_d.extCycle = 1'b1;
                    r_d.state = ST_CYCLE;
                end
            end
            ST_UPPER: begin
                r_d.strobeN = 1'b1;
                if (r_q.addrHold) begin
                    r_d.state = ST_HOLD;
                end else begin
                    r_d.extAddr = lower_of(r_q.curAddr, r_q.widthLog);
                    r_d.extCycle = 1'b1;
                    r_d.state = ST_CYCLE;
                end
            end
            ST_HOLD: begin
                r_d.extAddr = lower_of(r_q.curAddr, r_q.widthLog);
                r_d.extCycle = 1'b1;
                r_d.state = ST_CYCLE;
            end
            ST_CYCLE: begin
                r_d.cyclesLeft = 4'(r_q.cyclesLeft - 4'h1);
                // Lowest address first, step by one bus width
                r_d.curAddr = 36'(r_q.curAddr + (36'h1 << r_q.widthLog));
                if (r_q.cyclesLeft == 4'h1) begin
                    r_d.reqDone = 1'b1;
                    r_d.reqHit = 1'b1;
                    r_d.state = ST_IDLE;
                end else begin
                    r_d.state = ST_ADDR;
                end
            end
            default: r_d.state = ST_IDLE;
        endcase

        // Synchronous reset also catches the boot straps
        if (!resetn) begin
            r_d = '0;
            for (int c = 0; c < NUM_CH; c++) begin
                r_d.chLo[c] = CH_LO_RST;
            end
            r_d.chLo[0][F_EN] = strapAddr[P_EN0];
            r_d.chLo[0][F_SPD +: 2] = strapAddr[P_SPD0 +: 2];
            r_d.chLo[0][F_BLM] = strapData[P_BLM0];
            r_d.chLo[0][F_WT] = ~strapData[P_WT0];
            r_d.chLo[0][F_BW +: 2] = strapData[P_BW0 +: 2];
            r_d.sysDiv = strapAddr[P_DIV +: 2];
            r_d.ack_ready_pin_mode = 1'b0;
            r_d.addrHold = 1'b1;
            r_d.strobeN = 1'b1;
            r_d.state = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        r_q <= r_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign awready = !r_q.awHave && !r_q.bValid;
    assign wready = !r_q.wHave && !r_q.bValid;
    assign bvalid = r_q.bValid;
    assign bresp = r_q.bResp;
    assign arready = !r_q.rValid;
    assign rvalid = r_q.rValid;
    assign rdata = r_q.rData;
    assign rresp = r_q.rResp;
    assign reqReady = (r_q.state == ST_IDLE);
    assign reqDone = r_q.reqDone;
    assign reqHit = r_q.reqHit;
    assign extAddr = r_q.extAddr;
    assign upperAddrStrobeN = r_q.strobeN;
    assign extCycle = r_q.extCycle;
    assign extChan = r_q.curChan;
    assign extBusWidth = r_q.chLo[r_q.curChan][F_BW +: 2];
    assign extSpeed = r_q.chLo[r_q.curChan][F_SPD +: 2];
    assign extByteWriteMode = r_q.chLo[r_q.curChan][F_BLM];
    assign extWaitCount = r_q.chLo[r_q.curChan][F_WT +: 6];
    assign ackReadyPinMode = r_q.ack_ready_pin_mode;
    assign systemClockTick = r_q.sysTick;
endmodule
`default_nettype wire

// ==== ebc_ext_bus_chk.sv ====
// Port-level assertions for the external bus channel decode block
`timescale 1ns/100ps
`default_nettype none
module ebc_ext_bus_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    // Request and external side
    input wire logic reqReady,
    input wire logic reqDone,
    input wire logic reqHit,
    input wire logic extCycle,
    input wire logic upperAddrStrobeN,
    input wire logic systemClockTick
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_strobe_pulse: assert property (!upperAddrStrobeN |=> upperAddrStrobeN)
        else $error("upper strobe low for more than one cycle");
    chk_strobe_cycle: assert property ($fell(upperAddrStrobeN) |-> ##[1:3] extCycle)
        else $error("no external cycle after upper strobe");
    chk_cycle_gap: assert property (extCycle |=> !extCycle)
        else $error("external cycles back to back");
    chk_hit_done: assert property (reqDone && reqHit |-> $past(extCycle))
        else $error("hit finished without a final external cycle");
    chk_miss_quiet: assert property (reqDone && !reqHit |-> !$past(extCycle))
        else $error("miss produced an external cycle");
    chk_done_idle: assert property (reqDone |-> reqReady)
        else $error("request done while sequencer busy");
    chk_tick_period: assert property (systemClockTick |-> ##[1:4] systemClockTick)
        else $error("system clock tick period above four");
    chk_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    chk_read_resp: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    cov_strobe: cover property ($fell(upperAddrStrobeN));
    cov_miss: cover property (reqDone && !reqHit);
    cov_split: cover property (extCycle ##2 extCycle);
endmodule
bind ebc_ext_bus_ctrl ebc_ext_bus_chk chk (.clk(clk), .resetn(resetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .reqReady(reqReady), .reqDone(reqDone),
    .reqHit(reqHit), .extCycle(extCycle), .upperAddrStrobeN(upperAddrStrobeN),
    .systemClockTick(systemClockTick));
`default_nettype wire

// ==== ebc_ext_dev_model.sv ====
// External device side: upper address latch fed from the multiplexed address pins
`timescale 1ns/100ps
`default_nettype none
module ebc_ext_dev_model (
    // Clock
    input wire logic clk,
    // Address pins
    input wire logic [19:0] extAddr,
    input wire logic upperAddrStrobeN,
    input wire logic extCycle,
    // Latched view
    output logic [7:0] upperLatch,
    output logic fresh,
    output logic holdBad
);
    logic strobeLowQ;
    initial begin
        upperLatch = 8'h00;
        fresh = 1'b0;
        holdBad = 1'b0;
        strobeLowQ = 1'b0;
    end
    // Clock-sampled latch; fresh marks an upper value not yet used by a data cycle
    always @(posedge clk) begin
        strobeLowQ <= !upperAddrStrobeN;
        if (!upperAddrStrobeN) begin
            upperLatch <= extAddr[19:12];
            fresh <= 1'b1;
        end else if (extCycle) begin
            fresh <= 1'b0;
        end
        // A latch closed by the strobe edge needs the pins still stable one cycle later
        if (strobeLowQ && upperAddrStrobeN && extAddr[19:12] !== upperLatch) begin
            holdBad <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== test_ebc_ext_bus_ctrl.sv ====
// Self-checking bench for the external bus channel decode and address output block
`timescale 1ns/100ps
`default_nettype none
module test_ebc_ext_bus_ctrl
    import ebc_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [6:0] awaddr = 7'h00, araddr = 7'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic reqValid = 1'b0, reqBurst = 1'b0;
    logic [35:0] reqAddr = 36'h0;
    logic [1:0] reqSize = 2'h0, bresp, rresp;
    logic [19:0] strapAddr = 20'h02180, extAddr;
    logic [5:0] strapData = 6'h21;
    logic awready, wready, bvalid, arready, rvalid, reqReady, reqDone, reqHit;
    logic extCycle, upperAddrStrobeN, systemClockTick, fresh, holdBad;
    logic [2:0] extChan;
    logic [7:0] upperLatch;
    wire [11:0] chOut;
    logic [31:0] cycQ[$];
    logic hitQ[$];
    logic [15:0] lfsr = 16'hF130;
    int failures = 0, nTests = 0;

    ebc_ext_bus_ctrl DUT (
        .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .strapAddr(strapAddr), .strapData(strapData), .reqValid(reqValid),
        .reqReady(reqReady), .reqAddr(reqAddr), .reqSize(reqSize), .reqBurst(reqBurst),
        .reqDone(reqDone), .reqHit(reqHit), .extAddr(extAddr),
        .upperAddrStrobeN(upperAddrStrobeN), .extCycle(extCycle), .extChan(extChan),
        .extBusWidth(chOut[1:0]), .extSpeed(chOut[3:2]), .extByteWriteMode(chOut[4]),
        .extWaitCount(chOut[10:5]), .ackReadyPinMode(chOut[11]),
        .systemClockTick(systemClockTick));
    ebc_ext_dev_model PEER (.clk(clk), .extAddr(extAddr), .upperAddrStrobeN(upperAddrStrobeN),
        .extCycle(extCycle), .upperLatch(upperLatch), .fresh(fresh), .holdBad(holdBad));

    initial begin
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cmpBit(input logic got, input logic exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: wait ran out", $time);
            report_and_stop();
        end
    endtask
    function automatic logic [15:0] nextLfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        tmo(bvalid);
        cmpWord({30'h0, bresp}, {30'h0, RESP_OK});
        bready <= 1'b0;
        // Let one edge pass so a following write never reassigns bready in this step
        @(posedge clk);
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        tmo(rvalid);
        cmpWord(rdata, d);
        cmpWord({30'h0, rresp}, {30'h0, r});
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // The hit flag is noted before the request goes out so the watcher never runs dry
    task automatic rq(input logic [35:0] a, input logic [1:0] s, input logic b, input logic h);
        int n;
        hitQ.push_back(h);
        reqAddr <= a;
        reqSize <= s;
        reqBurst <= b;
        reqValid <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!reqReady && n < 40);
        reqValid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (!reqDone && n < 80);
        tmo(reqDone);
    endtask
    task automatic tickGap;
        int n;
        int g;
        n = 0;
        g = 0;
        repeat (12) begin
            @(posedge clk);
            g++;
            if (systemClockTick === 1'b1) begin
                if (n > 0) cmpWord(32'(g), 32'h3);
                n++;
                g = 0;
            end
        end
        cmpBit(n > 2, 1'b1);
    endtask
    // Watcher: each data cycle and each finished request takes the oldest note
    always @(posedge clk) begin
        if (extCycle === 1'b1) begin
            if (cycQ.size() == 0) cmpWord(32'h0, 32'h1);
            else cmpWord({fresh, extChan, upperLatch, extAddr}, cycQ.pop_front());
        end
        if (reqDone === 1'b1) begin
            if (hitQ.size() == 0) cmpBit(1'b0, 1'b1);
            else cmpBit(reqHit, hitQ.pop_front());
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        strapAddr <= ~20'h02180;
        strapData <= ~6'h21;
        @(posedge clk);
        rd(7'h00, 32'h0000041D, RESP_OK);
        cmpWord({20'h0, chOut}, 32'h00000039);
        rd(OFS_CFG, 32'h00000006, RESP_OK);
        rd(OFS_CH_STRIDE, 32'h0, RESP_OK);
        rd(7'h7C, 32'h0, RESP_SLVERR);
        tickGap();
        $display("test boot straps done");
        cycQ.push_back({1'b1, 3'h0, 8'h00, 20'h00004});
        rq(36'h0_0000_0010, 2'h2, 1'b0, 1'b1);
        cycQ.push_back({1'b0, 3'h0, 8'h00, 20'h00006});
        cycQ.push_back({1'b0, 3'h0, 8'h00, 20'h00007});
        rq(36'h0_0000_0018, SZ_DWORD, 1'b0, 1'b1);
        repeat (3) begin
            lfsr = nextLfsr(lfsr);
            cycQ.push_back({1'b0, 3'h0, 8'h00, 2'h0, lfsr, 2'h0});
            rq({16'h0, lfsr, 4'h0}, 2'h2, 1'b0, 1'b1);
        end
        $display("test channel 0 done");
        wr(7'h0C, 32'h00000040);
        wr(7'h08, 32'h00001C01);
        rd(7'h08, 32'h00001C01, RESP_OK);
        cycQ.push_back({1'b1, 3'h1, 8'h41, 20'hFFFFE});
        cycQ.push_back({1'b0, 3'h1, 8'h41, 20'hFFFFF});
        rq(36'h0_041F_FFFE, 2'h1, 1'b0, 1'b1);
        cycQ.push_back({1'b1, 3'h1, 8'h40, 20'h00000});
        rq(36'h0_0400_0000, 2'h0, 1'b0, 1'b1);
        cycQ.push_back({1'b0, 3'h1, 8'h40, 20'h00005});
        rq(36'h0_0400_0005, 2'h0, 1'b0, 1'b1);
        wr(7'h08, 32'h00002801);
        cycQ.push_back({1'b1, 3'h1, 8'h21, 20'h00002});
        cycQ.push_back({1'b0, 3'h1, 8'h21, 20'h00003});
        rq(36'h0_0420_0004, 2'h2, 1'b0, 1'b1);
        cycQ.push_back({1'b0, 3'h0, 8'h21, 20'h00008});
        cycQ.push_back({1'b0, 3'h0, 8'h21, 20'h00009});
        rq(36'h0_0000_0020, 2'h0, 1'b1, 1'b1);
        $display("test narrow channels done");
        rq(36'h8_0000_0000, 2'h2, 1'b0, 1'b0);
        wr(7'h08, 32'h00002800);
        rq(36'h0_0420_0004, 2'h2, 1'b0, 1'b0);
        wr(7'h08, 32'h0000B801);
        rq(36'h0_0420_0004, 2'h2, 1'b0, 1'b0);
        wr(OFS_CFG, 32'h00000003);
        rd(OFS_CFG, 32'h00000007, RESP_OK);
        cmpBit(chOut[11], 1'b1);
        // Second reset with the inverted straps: boot channel off, 16-bit, half speed
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(7'h00, 32'h00000802, RESP_OK);
        cmpWord({20'h0, chOut}, 32'h00000006);
        rq(36'h0_0000_0010, 2'h2, 1'b0, 1'b0);
        wr(OFS_CFG, 32'h00000000);
        rd(OFS_CFG, 32'h00000008, RESP_OK);
        wr(7'h00, 32'h00000801);
        cycQ.push_back({1'b1, 3'h0, 8'h00, 20'h00008});
        rq(36'h0_0000_0010, 2'h0, 1'b0, 1'b1);
        $display("test second reset done");
        cmpBit(holdBad, 1'b0);
        cmpWord(32'(cycQ.size()), 32'h0);
        $display("test misses done");
        report_and_stop();
    end
endmodule
`default_nettype wire
